/* fcs_monitor.sv */
`timescale 1ns/1ns
module fcs_monitor (
  input wire logic core_clk, // clock
  input wire logic reset, // reset
  input wire logic [fcs_pkg::MODE_W-1:0] mode_sel, // mode pins
  input wire logic ready_in, // ready line
  input wire logic reprogram_request_n, // reprogram pin
  input wire logic ready_oe_n, // ready drive
  input wire logic load_clock_o, // master clock
  input wire logic load_clock_oe_n, // clock drive
  input wire logic done_oe_n, // done drive
  input wire logic high_during_load, // load enable
  input wire logic low_during_load, // load enable
  input wire logic cell_hold, // cells held
  input wire logic pin_float_pullup, // pins floated
  input wire logic internal_tristate_buffer_off, // buffers off
  input wire logic [fcs_pkg::MODE_W-1:0] mode_latched, // sampled mode
  input fcs_pkg::fcs_mem_wr_t mem_wr, // memory write
  input fcs_pkg::fcs_state_t state_o // state
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  por_outputs_a: assert property (state_o == fcs_pkg::FCS_POR |-> !ready_oe_n && !done_oe_n)
    else $error("outputs not low in power-on");
  load_enables_a: assert property (state_o < fcs_pkg::FCS_START && $past(state_o) < fcs_pkg::FCS_START
    |-> high_during_load && !low_during_load && !done_oe_n) else $error("load enables wrong");
  ready_release_a: assert property (state_o == fcs_pkg::FCS_INIT && $past(state_o) == fcs_pkg::FCS_INIT
    |-> ready_oe_n) else $error("ready line not released");
  init_wait_a: assert property ((state_o == fcs_pkg::FCS_INIT && !ready_in)[*4]
    |=> state_o == fcs_pkg::FCS_INIT) else $error("left init while ready low");
  config_entry_a: assert property ($rose(state_o == fcs_pkg::FCS_CONFIG)
    |-> $past(ready_in, 4) && mode_latched == mode_sel) else $error("bad config entry");
  master_extend_a: assert property ($rose(state_o == fcs_pkg::FCS_EXTEND)
    |-> (mode_latched[3] && state_o == fcs_pkg::FCS_EXTEND)[*6]) else $error("extend too short");
  clock_drive_a: assert property (state_o == fcs_pkg::FCS_CONFIG
    |-> load_clock_oe_n == !mode_latched[fcs_pkg::MODE_MASTER_BIT]) else $error("clock drive wrong");
  clock_config_a: assert property ($changed(load_clock_o)
    |-> $past(state_o) == fcs_pkg::FCS_CONFIG || !load_clock_o)
    else $error("clock moved outside load");
  cells_held_a: assert property (state_o == fcs_pkg::FCS_CONFIG
    |-> cell_hold && pin_float_pullup && internal_tristate_buffer_off) else $error("cells free");
  reset_ignored_a: assert property ((state_o == fcs_pkg::FCS_OPER && reprogram_request_n)[*6]
    |=> state_o == fcs_pkg::FCS_OPER) else $error("left operation without reprogram");
  start_oper_a: assert property (state_o == fcs_pkg::FCS_START |=> state_o == fcs_pkg::FCS_OPER)
    else $error("start not followed by operation");
  cover property ($rose(state_o == fcs_pkg::FCS_OPER));
  cover property ($rose(state_o == fcs_pkg::FCS_EXTEND));
  cover property (mem_wr.we && state_o == fcs_pkg::FCS_CONFIG);
  cover property ($changed(load_clock_o));
endmodule
bind fcs_sequencer fcs_monitor fcs_monitor_i (.core_clk, .reset, .mode_sel, .ready_in,
  .reprogram_request_n, .ready_oe_n, .load_clock_o, .load_clock_oe_n, .done_oe_n,
  .high_during_load, .low_during_load, .cell_hold, .pin_float_pullup,
  .internal_tristate_buffer_off, .mode_latched, .mem_wr, .state_o);

/* fcs_pkg.sv */
package fcs_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int MODE_W = 4;
  localparam int WORD_W = 32;
  localparam int LEN_W = 24;
  localparam int ADDR_W = 16;
  localparam int SYNC_STAGES = 3;
  // ready line must stay high this many internal cycles
  localparam logic [3:0] READY_HIGH_CYCLES = 4'h2;
  // extra initialization cycles in master modes
  localparam logic [3:0] MASTER_EXTRA_CYCLES = 4'h6;
  // power-on initialization delay in internal cycles
  localparam logic [7:0] POR_CYCLES = 8'h10;
  // clear of configuration memory, one word per cycle
  localparam logic [ADDR_W-1:0] CLEAR_LAST_ADDR = 16'h00FF;
  // master load clock divider terminal count; half period is one more internal cycle
  localparam logic [3:0] LOAD_CLK_HALF = 4'h4;
  // mode select bit that marks a master mode
  localparam int MODE_MASTER_BIT = 3;
  // header word: marker in top byte, length count below
  localparam logic [7:0] HDR_MARK = 8'hF2;
  localparam logic [7:0] END_MARK = 8'hFE;
  localparam int MARK_LSB = 24;

  typedef enum logic [2:0] {
    FCS_POR    = 3'b000,
    FCS_CLEAR  = 3'b001,
    FCS_INIT   = 3'b010,
    FCS_EXTEND = 3'b011,
    FCS_CONFIG = 3'b100,
    FCS_START  = 3'b101,
    FCS_OPER   = 3'b110
  } fcs_state_t;

  typedef struct packed {
    logic high_during_load;
    logic low_during_load;
    logic done_low;
    logic hold_cells;
    logic float_pins;
  } fcs_status_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } fcs_mem_wr_t;

endpackage

/* fcs_sequencer.sv */
`timescale 1ns/1ns
// Behaviour
// - ready and completion low during power-on
// - pin functions follow mode select at power-up
// - clear configuration memory unless skip selected on reconfiguration
// - release ready line; wait while held low
// - ready high two cycles, sample mode
// - drive load enables during init and config
// - reset or reprogram aborts; wait both high
// - ignore reset after configuration; reprogram only
// - master modes drive the load clock
// - master modes add six init cycles
// - clear counter, count load clock cycles
// - assemble frame bits into memory words
// - complete when count matches and end written
// - unused pins floated with pull-ups
// - hold cells reset, tristate buffers off
// - enter start-up on count and end frame
// - reprogram pulse clears, floats, resamples, reloads
module fcs_sequencer (
  input wire logic core_clk, // internal clock, 10 MHz
  input wire logic reset, // async power-on reset, high
  input wire logic [fcs_pkg::MODE_W-1:0] mode_sel, // mode select pins
  input wire logic ready_in, // wired-AND ready line level
  input wire logic chip_reset_n, // device reset pin, low active
  input wire logic reprogram_request_n, // reprogram pin, low active
  input wire logic skip_clear, // keep memory on reconfiguration
  input wire logic load_clock_in, // load clock from source (slave)
  input wire logic load_data_in, // serial configuration data
  output logic ready_o, // ready line drive value (always 0)
  output logic ready_oe_n, // ready line enable, low = pull low
  output logic load_clock_o, // load clock driven in master modes
  output logic load_clock_oe_n, // load clock enable, low = drive
  output logic done_o, // completion drive value (always 0)
  output logic done_oe_n, // completion enable, low = pull low
  output logic high_during_load, // high during init and config
  output logic low_during_load, // low during init and config
  output logic pin_float_pullup, // unused pins floated, pull-ups on
  output logic cell_hold, // io_cell and logic_cell storage held
  output logic internal_tristate_buffer_off, // internal buffers off
  output logic [fcs_pkg::MODE_W-1:0] mode_latched, // sampled mode
  output fcs_pkg::fcs_mem_wr_t mem_wr, // configuration memory write
  output fcs_pkg::fcs_state_t state_o // current state
);
  fcs_pkg::fcs_state_t state_r, state_nxt;
  logic ready_s, rst_s, prg_s, prg_fall, lclk_rise;
  logic [7:0] por_cnt_r;
  logic [3:0] wait_cnt_r;
  logic [3:0] div_cnt_r;
  logic master_r, first_cfg_r, hdr_seen_r, end_seen_r;
  logic [fcs_pkg::LEN_W-1:0] cycle_cnt_r, len_r;
  logic [fcs_pkg::WORD_W-1:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic [fcs_pkg::ADDR_W-1:0] addr_r;
  logic lclk_edge, abort;

  function automatic logic [7:0] word_mark(input logic [fcs_pkg::WORD_W-1:0] w);
    word_mark = w[fcs_pkg::MARK_LSB +: 8];
  endfunction

  fcs_sync u_ready (.core_clk(core_clk), .reset(reset), .din(ready_in), .rst_val(1'b1),
    .dout(ready_s), .rise(), .fall());
  fcs_sync u_rst (.core_clk(core_clk), .reset(reset), .din(chip_reset_n), .rst_val(1'b1),
    .dout(rst_s), .rise(), .fall());
  fcs_sync u_prg (.core_clk(core_clk), .reset(reset), .din(reprogram_request_n),
    .rst_val(1'b1), .dout(prg_s), .rise(), .fall(prg_fall));
  fcs_sync u_lclk (.core_clk(core_clk), .reset(reset), .din(load_clock_in), .rst_val(1'b1),
    .dout(), .rise(lclk_rise), .fall());

  // master clock edge comes from own divider
  assign lclk_edge = master_r ? (div_cnt_r == fcs_pkg::LOAD_CLK_HALF && !load_clock_o)
                              : lclk_rise;

  // abort on reset or reprogram during loading, on reprogram only after it
  always_comb
  begin
    abort = 1'b0;
    if (state_r == fcs_pkg::FCS_CONFIG && (!rst_s || !prg_s))
      abort = 1'b1;
    if ((state_r == fcs_pkg::FCS_START || state_r == fcs_pkg::FCS_OPER) && prg_fall)
      abort = 1'b1;
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      fcs_pkg::FCS_POR:
        if (por_cnt_r == fcs_pkg::POR_CYCLES)
          state_nxt = fcs_pkg::FCS_CLEAR;
      // clear memory unless skipped on reconfiguration
      fcs_pkg::FCS_CLEAR:
        if ((skip_clear && !first_cfg_r) || addr_r == fcs_pkg::CLEAR_LAST_ADDR)
          state_nxt = fcs_pkg::FCS_INIT;
      // wait while ready line held low
      // two high cycles then sample mode
      // also wait for both pins high
      fcs_pkg::FCS_INIT:
        if (ready_s && rst_s && prg_s && wait_cnt_r == fcs_pkg::READY_HIGH_CYCLES)
          state_nxt = mode_sel[fcs_pkg::MODE_MASTER_BIT] ? fcs_pkg::FCS_EXTEND
                                                        : fcs_pkg::FCS_CONFIG;
      // six further cycles in master modes
      fcs_pkg::FCS_EXTEND:
        if (!ready_s)
          state_nxt = fcs_pkg::FCS_INIT;
        else if (wait_cnt_r == fcs_pkg::MASTER_EXTRA_CYCLES)
          state_nxt = fcs_pkg::FCS_CONFIG;
      // count match and end frame written
      fcs_pkg::FCS_CONFIG:
        if (end_seen_r && hdr_seen_r && cycle_cnt_r == len_r)
          state_nxt = fcs_pkg::FCS_START;
      fcs_pkg::FCS_START:
        state_nxt = fcs_pkg::FCS_OPER;
      fcs_pkg::FCS_OPER:
        state_nxt = fcs_pkg::FCS_OPER;
      default:
        state_nxt = fcs_pkg::FCS_POR;
    endcase
    if (abort)
      state_nxt = fcs_pkg::FCS_CLEAR;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      state_r <= fcs_pkg::FCS_POR;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      por_cnt_r <= 8'h00;
    else if (state_r == fcs_pkg::FCS_POR)
      por_cnt_r <= por_cnt_r + 8'h01;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      wait_cnt_r <= 4'h0;
    else if (state_r != state_nxt)
      wait_cnt_r <= 4'h0;
    // count restarts until ready, reset and reprogram are all high
    else if (state_r == fcs_pkg::FCS_INIT && !(ready_s && rst_s && prg_s))
      wait_cnt_r <= 4'h0;
    else if (wait_cnt_r != 4'hF)
      wait_cnt_r <= wait_cnt_r + 4'h1;
  end

  // first load clears memory always; later ones may skip
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      first_cfg_r <= 1'b1;
    else if (state_r == fcs_pkg::FCS_START)
      first_cfg_r <= 1'b0;
  end

  // sample mode lines on entry to config path
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_latched <= 4'h0;
      master_r <= 1'b0;
    end
    else if (state_r == fcs_pkg::FCS_POR ||
             (state_r == fcs_pkg::FCS_INIT && state_nxt != fcs_pkg::FCS_INIT))
    begin
      mode_latched <= mode_sel;
      master_r <= mode_sel[fcs_pkg::MODE_MASTER_BIT];
    end
  end

  // load clock divider, runs only while loading
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt_r <= 4'h0;
      load_clock_o <= 1'b0;
      load_clock_oe_n <= 1'b1;
    end
    else
    begin
      load_clock_oe_n <= ~(master_r && state_r != fcs_pkg::FCS_POR);
      if (master_r && state_r == fcs_pkg::FCS_CONFIG)
      begin
        if (div_cnt_r == fcs_pkg::LOAD_CLK_HALF)
        begin
          div_cnt_r <= 4'h0;
          load_clock_o <= ~load_clock_o;
        end
        else
          div_cnt_r <= div_cnt_r + 4'h1;
      end
      else
      begin
        div_cnt_r <= 4'h0;
        load_clock_o <= 1'b0;
      end
    end
  end

  // counter cleared at start, counts load clocks
  // assemble bits into words, write each word after the header
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cycle_cnt_r <= 24'h000000;
      shift_r <= 32'h00000000;
      bit_cnt_r <= 5'h00;
      addr_r <= 16'h0000;
      len_r <= 24'hFFFFFF;
      hdr_seen_r <= 1'b0;
      end_seen_r <= 1'b0;
      mem_wr <= '0;
    end
    else
    begin
      mem_wr.we <= 1'b0;
      if (state_r == fcs_pkg::FCS_CLEAR)
      begin
        mem_wr.we <= ~(skip_clear && !first_cfg_r);
        mem_wr.addr <= addr_r;
        mem_wr.data <= 32'h00000000;
        addr_r <= addr_r + 16'h0001;
      end
      if (state_r != fcs_pkg::FCS_CONFIG)
      begin
        cycle_cnt_r <= 24'h000000;
        bit_cnt_r <= 5'h00;
        hdr_seen_r <= 1'b0;
        end_seen_r <= 1'b0;
        len_r <= 24'hFFFFFF;
        if (state_r != fcs_pkg::FCS_CLEAR)
          addr_r <= 16'h0000;
      end
      else if (lclk_edge)
      begin
        cycle_cnt_r <= cycle_cnt_r + 24'h000001;
        shift_r <= {shift_r[fcs_pkg::WORD_W-2:0], load_data_in};
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == 5'h1F)
        begin
          if (!hdr_seen_r)
          begin
            if (word_mark({shift_r[30:0], load_data_in}) == fcs_pkg::HDR_MARK)
            begin
              hdr_seen_r <= 1'b1;
              len_r <= {shift_r[22:0], load_data_in};
            end
          end
          else
          begin
            mem_wr.we <= 1'b1;
            mem_wr.addr <= addr_r;
            mem_wr.data <= {shift_r[30:0], load_data_in};
            addr_r <= addr_r + 16'h0001;
            if (word_mark({shift_r[30:0], load_data_in}) == fcs_pkg::END_MARK)
              end_seen_r <= 1'b1;
          end
        end
      end
      // an aborted load restarts the clear from the first word
      if (abort)
        addr_r <= 16'h0000;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ready_o <= 1'b0;
      ready_oe_n <= 1'b0;
      done_o <= 1'b0;
      done_oe_n <= 1'b0;
      high_during_load <= 1'b1;
      low_during_load <= 1'b0;
      pin_float_pullup <= 1'b1;
      cell_hold <= 1'b1;
      internal_tristate_buffer_off <= 1'b1;
      state_o <= fcs_pkg::FCS_POR;
    end
    else
    begin
      ready_o <= 1'b0;
      ready_oe_n <= ~(state_nxt == fcs_pkg::FCS_POR || state_nxt == fcs_pkg::FCS_CLEAR);
      done_o <= 1'b0;
      done_oe_n <= (state_nxt == fcs_pkg::FCS_START || state_nxt == fcs_pkg::FCS_OPER);
      high_during_load <= (state_nxt != fcs_pkg::FCS_START && state_nxt != fcs_pkg::FCS_OPER);
      low_during_load <= (state_nxt == fcs_pkg::FCS_START || state_nxt == fcs_pkg::FCS_OPER);
      pin_float_pullup <= (state_nxt != fcs_pkg::FCS_OPER);
      cell_hold <= (state_nxt != fcs_pkg::FCS_OPER);
      internal_tristate_buffer_off <= (state_nxt != fcs_pkg::FCS_OPER);
      state_o <= state_nxt;
    end
  end
endmodule

/* fcs_source.sv */
`timescale 1ns/1ns
module fcs_source (
  output logic load_clock, // serial load clock
  output logic load_data // serial data
);
  initial
  begin
    load_clock = 1'b0;
    load_data = 1'b0;
  end
  // msb first; data moves mid low phase, clock idles low between frames
  task automatic send_word(input logic [31:0] w);
    #37;
    for (int i = 31; i >= 0; i--)
    begin
      #200 load_data = w[i];
      #200 load_clock = 1'b1;
      #400 load_clock = 1'b0;
    end
    #200 load_data = !load_data;
  endtask
endmodule

/* fcs_sync.sv */
`timescale 1ns/1ns
module fcs_sync (
  input wire logic core_clk, // internal clock
  input wire logic reset, // async reset, high
  input wire logic din, // asynchronous input
  input wire logic rst_val, // unused level kept constant by caller
  output logic dout, // stable level
  output logic rise, // one-cycle pulse on rising change
  output logic fall // one-cycle pulse on falling change
);
  logic [fcs_pkg::SYNC_STAGES-1:0] sh_r;

  // a change counts once stages two and three agree
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sh_r <= 3'h7;
      dout <= 1'b1;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      sh_r <= {sh_r[1:0], din};
      rise <= 1'b0;
      fall <= 1'b0;
      if (sh_r[1] == sh_r[2] && sh_r[2] != dout)
      begin
        dout <= sh_r[2];
        rise <= sh_r[2];
        fall <= ~sh_r[2];
      end
    end
  end

  logic unused_ok;
  assign unused_ok = rst_val;
endmodule

/* testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic core_clk, reset, ext_ready, chip_reset_n, reprogram_request_n, skip_clear;
  logic load_clock_in, load_data_in, ready_o, ready_oe_n, load_clock_o, load_clock_oe_n;
  logic done_o, done_oe_n, high_during_load, low_during_load, pin_float_pullup, cell_hold;
  logic internal_tristate_buffer_off, loading, w;
  logic [3:0] mode_sel, mode_latched;
  fcs_pkg::fcs_mem_wr_t mem_wr;
  fcs_pkg::fcs_state_t state_o;
  int failures, n_tests, exp_addr, n_clear, n_start;
  logic [31:0] exp_q[$];
  wire ready_in = ready_oe_n & ext_ready;
  fcs_sequencer fcs_sequencer_i (.core_clk, .reset, .mode_sel, .ready_in, .chip_reset_n,
    .reprogram_request_n, .skip_clear, .load_clock_in, .load_data_in, .ready_o, .ready_oe_n,
    .load_clock_o, .load_clock_oe_n, .done_o, .done_oe_n, .high_during_load, .low_during_load,
    .pin_float_pullup, .cell_hold, .internal_tristate_buffer_off, .mode_latched, .mem_wr,
    .state_o);
  fcs_source fcs_source_i (.load_clock(load_clock_in), .load_data(load_data_in));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_state(input fcs_pkg::fcs_state_t s, input int lim);
    int k;
    k = 0;
    while (state_o !== s && k < lim)
    begin
      @(negedge core_clk);
      k++;
    end
    check("state", state_o, s);
  endtask
  task automatic pulse_reprogram;
    reprogram_request_n = 1'b0;
    repeat (3) @(negedge core_clk);
    reprogram_request_n = 1'b1;
  endtask
  task automatic load(input int n);
    logic [31:0] d;
    int s0;
    s0 = n_start;
    loading = 1'b1;
    exp_addr = 0;
    fcs_source_i.send_word({fcs_pkg::HDR_MARK, 24'((n + 2) * 32)});
    for (int i = 0; i <= n; i++)
    begin
      d = $urandom;
      if (i == n)
        d[31:24] = fcs_pkg::END_MARK;
      else if (d[31:24] inside {fcs_pkg::HDR_MARK, fcs_pkg::END_MARK})
        d[31:24] = 8'h00;
      exp_q.push_back(d);
      fcs_source_i.send_word(d);
    end
    wait_state(fcs_pkg::FCS_OPER, 20);
    check("start", n_start, s0 + 1);
    loading = 1'b0;
    check("unwritten", exp_q.size(), 0);
  endtask
  // start lasts one cycle; count it where it stands
  always @(negedge core_clk)
    if (state_o === fcs_pkg::FCS_START)
      n_start++;
  // reference model of memory writes
  always @(negedge core_clk)
    if (mem_wr.we === 1'b1)
    begin
      if (loading)
      begin
        check("mem_addr", mem_wr.addr, exp_addr);
        check("mem_data", mem_wr.data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        exp_addr++;
      end
      else
      begin
        check("clear_data", mem_wr.data, 32'h0);
        n_clear++;
      end
    end
  initial
  begin
    #2000000;
    failures++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(53603));
    reset = 1'b1;
    mode_sel = 4'h0;
    ext_ready = 1'b0;
    chip_reset_n = 1'b1;
    reprogram_request_n = 1'b1;
    skip_clear = 1'b0;
    loading = 1'b0;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    check("por_state", state_o, fcs_pkg::FCS_POR);
    check("por_out", {ready_oe_n, done_oe_n, high_during_load, low_during_load}, 4'h2);
    $display("test power_on done");
    wait_state(fcs_pkg::FCS_INIT, 400);
    @(negedge core_clk);
    check("clears", n_clear, int'(fcs_pkg::CLEAR_LAST_ADDR) + 1);
    repeat (30) @(negedge core_clk);
    check("held", state_o, fcs_pkg::FCS_INIT);
    ext_ready = 1'b1;
    wait_state(fcs_pkg::FCS_CONFIG, 20);
    check("mode", mode_latched, 4'h0);
    $display("test init done");
    load(3);
    check("released", {done_oe_n, high_during_load, low_during_load, cell_hold,
      pin_float_pullup, internal_tristate_buffer_off}, 6'h28);
    chip_reset_n = 1'b0;
    repeat (10) @(negedge core_clk);
    check("rst_ignored", state_o, fcs_pkg::FCS_OPER);
    chip_reset_n = 1'b1;
    skip_clear = 1'b1;
    pulse_reprogram;
    wait_state(fcs_pkg::FCS_CONFIG, 100);
    check("skip", n_clear, int'(fcs_pkg::CLEAR_LAST_ADDR) + 1);
    load(2);
    $display("test reprogram done");
    pulse_reprogram;
    wait_state(fcs_pkg::FCS_CONFIG, 100);
    loading = 1'b1;
    fork
      fcs_source_i.send_word({8'h00, 24'($urandom)});
    join_none
    repeat (100) @(negedge core_clk);
    chip_reset_n = 1'b0;
    repeat (300) @(negedge core_clk);
    check("abort", state_o, fcs_pkg::FCS_INIT);
    chip_reset_n = 1'b1;
    wait_state(fcs_pkg::FCS_CONFIG, 20);
    load(1);
    $display("test abort done");
    mode_sel = 4'h8;
    pulse_reprogram;
    wait_state(fcs_pkg::FCS_EXTEND, 100);
    wait_state(fcs_pkg::FCS_CONFIG, 20);
    check("master", {mode_latched, load_clock_oe_n}, 5'h10);
    w = load_clock_o;
    repeat (5) @(negedge core_clk);
    check("mclk", load_clock_o, !w);
    $display("test master done");
    tally_and_finish;
  end
endmodule
